// ===== design/tpe_cfg.svh
`ifndef TPE_CFG_SVH
`define TPE_CFG_SVH

// comma group, both running-disparity forms
`define TPE_K285_NEG   10'h17C
`define TPE_K285_POS   10'h283
`define TPE_COMMA_BYTE 8'hBC
// comma byte as it stands before the per-byte bit flip
`define TPE_FLIP_COMMA 8'h3D
`define TPE_ZERO_WORD  10'h000

// serializer phases, two bits leave per parallel clock
`define TPE_LAST_W10   3'h4
`define TPE_LAST_W8    3'h3
`define TPE_PHASE_ZERO 3'h0
`define TPE_PHASE_STEP 3'h1

// comma groups sent after the digital reset drops
`define TPE_SYNC_LAST  2'h2
`define TPE_SYNC_STEP  2'h1
`define TPE_SYNC_ZERO  2'h0

// largest bit delay applied; larger slip requests clamp to it
`define TPE_SLIP_MAX   4'h9
`define TPE_SLIP_STEP  5'h01

// code-group construction
`define TPE_K28_X      5'h1C
`define TPE_D7_X       5'h07
`define TPE_Y3         3'h3
`define TPE_Y7         3'h7
`define TPE_ALT_FGHJ   4'h7
`define TPE_SIX_K28    6'h0F
`define TPE_X17        5'h11
`define TPE_X18        5'h12
`define TPE_X20        5'h14
`define TPE_X11        5'h0B
`define TPE_X13        5'h0D
`define TPE_X14        5'h0E

`endif

// ===== design/tpe_encoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpe_cfg.svh"

module tpe_encoder (
  input  wire logic [7:0] data_in,
  input  wire logic       k_in,
  input  wire logic       rd_neg_in,
  output logic      [9:0] code_out,
  output logic            rd_neg_out
);

  function automatic logic [5:0] six_of(input logic [4:0] x);
    logic [5:0] t;
    case (x)
      5'h00: t = 6'h27;  5'h01: t = 6'h1D;  5'h02: t = 6'h2D;  5'h03: t = 6'h31;
      5'h04: t = 6'h35;  5'h05: t = 6'h29;  5'h06: t = 6'h19;  5'h07: t = 6'h38;
      5'h08: t = 6'h39;  5'h09: t = 6'h25;  5'h0A: t = 6'h15;  5'h0B: t = 6'h34;
      5'h0C: t = 6'h0D;  5'h0D: t = 6'h2C;  5'h0E: t = 6'h1C;  5'h0F: t = 6'h17;
      5'h10: t = 6'h1B;  5'h11: t = 6'h23;  5'h12: t = 6'h13;  5'h13: t = 6'h32;
      5'h14: t = 6'h0B;  5'h15: t = 6'h2A;  5'h16: t = 6'h1A;  5'h17: t = 6'h3A;
      5'h18: t = 6'h33;  5'h19: t = 6'h26;  5'h1A: t = 6'h16;  5'h1B: t = 6'h36;
      5'h1C: t = 6'h0E;  5'h1D: t = 6'h2E;  5'h1E: t = 6'h1E;  default: t = 6'h2B;
    endcase
    return t;
  endfunction : six_of

  function automatic logic [3:0] four_of(input logic [2:0] y);
    logic [3:0] t;
    case (y)
      3'h0: t = 4'hB;  3'h1: t = 4'h9;  3'h2: t = 4'h5;  3'h3: t = 4'hC;
      3'h4: t = 4'hD;  3'h5: t = 4'hA;  3'h6: t = 4'h6;  default: t = 4'hE;
    endcase
    return t;
  endfunction : four_of

  logic [4:0] x;
  logic [2:0] y;
  logic       k28;
  logic       rd;
  logic       rd_mid;
  logic       alt;
  logic [5:0] six;
  logic [3:0] four;
  logic [9:0] code;
  logic       rd_end;

  // tables are written a-first; the line sends bit a first, so it lands in bit 0
  always_comb begin
    x      = data_in[4:0];
    y      = data_in[7:5];
    k28    = k_in && (x == `TPE_K28_X);
    rd     = k28 ? 1'h1 : rd_neg_in;
    six    = k28 ? `TPE_SIX_K28 : six_of(x);
    if (!rd && (($countones(six) != 3) || (x == `TPE_D7_X))) begin
      six = ~six;
    end
    rd_mid = ($countones(six) != 3) ? ~rd : rd;
    alt    = (y == `TPE_Y7) && (k_in ||
             (rd_mid ? (x == `TPE_X17 || x == `TPE_X18 || x == `TPE_X20)
                     : (x == `TPE_X11 || x == `TPE_X13 || x == `TPE_X14)));
    four   = alt ? `TPE_ALT_FGHJ : four_of(y);
    if (!rd_mid && (($countones(four) != 2) || (y == `TPE_Y3))) begin
      four = ~four;
    end
    rd_end = ($countones(four) != 2) ? ~rd_mid : rd_mid;
    for (int i = 0; i < 6; i++) begin
      code[i] = six[5 - i];
    end
    for (int i = 0; i < 4; i++) begin
      code[6 + i] = four[3 - i];
    end
    // the comma family is fully complemented for the positive column
    if (k28 && !rd_neg_in) begin
      code   = ~code;
      rd_end = ~rd_end;
    end
    code_out   = code;
    rd_neg_out = rd_end;
  end

endmodule : tpe_encoder

`default_nettype wire

// ===== design/tpe_pkg.sv
package tpe_pkg;

  typedef enum logic [0:0] {
    TPE_SYNC,
    TPE_DATA
  } tpe_mode_e;

  // static and per-word controls from the fabric
  typedef struct packed {
    logic       enc_en;
    logic       width10;
    logic       bitflip;
    logic       invert;
    logic       reverse;
    logic       force_disp;
    logic       disp_val;
    logic       ctrl_k;
    logic [3:0] slip;
  } tpe_ctrl_s;

  typedef struct packed {
    tpe_mode_e  mode;
    logic [1:0] sync_cnt;
    logic       rd_neg;
    logic [2:0] phase;
    logic       take;
    logic       busy;
    logic [9:0] code;
    logic [9:0] shreg;
    logic [19:0] hist;
    logic [1:0] ser;
  } tpe_state_s;

endpackage : tpe_pkg

// ===== design/tpe_tx_pcs.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpe_cfg.svh"

module tpe_tx_pcs (
  input  wire logic                clk_in,
  input  wire logic                nrst_in,
  input  wire logic                dreset_in,
  input  wire tpe_pkg::tpe_ctrl_s  ctrl_in,
  input  wire logic          [9:0] data_in,
  output logic                     take_out,
  output logic               [1:0] ser_out,
  output logic               [9:0] code_out,
  output logic                     rd_neg_out,
  output logic                     sync_busy_out
);

  localparam tpe_pkg::tpe_state_s RST_STATE = '{
    mode:     tpe_pkg::TPE_SYNC,
    sync_cnt: `TPE_SYNC_ZERO,
    rd_neg:   1'h1,
    phase:    `TPE_PHASE_ZERO,
    take:     1'h0,
    busy:     1'h1,
    code:     `TPE_ZERO_WORD,
    shreg:    `TPE_ZERO_WORD,
    hist:     20'h00000,
    ser:      2'h0
  };

  function automatic logic [7:0] flip_byte(input logic [7:0] b);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7 - i];
    end
    return r;
  endfunction : flip_byte

  function automatic logic [9:0] reverse_word(input logic [9:0] w, input logic wide);
    logic [9:0] r;
    r = `TPE_ZERO_WORD;
    if (wide) begin
      for (int i = 0; i < 10; i++) begin
        r[i] = w[9 - i];
      end
    end else begin
      r[7:0] = flip_byte(w[7:0]);
    end
    return r;
  endfunction : reverse_word

  function automatic logic [2:0] last_phase(input logic wide);
    return wide ? `TPE_LAST_W10 : `TPE_LAST_W8;
  endfunction : last_phase

  tpe_pkg::tpe_state_s state;
  tpe_pkg::tpe_state_s next_state;

  logic       wide;
  logic       load;
  logic [7:0] enc_byte;
  logic       enc_k;
  logic       enc_rd;
  logic [9:0] enc_code;
  logic       enc_rd_end;
  logic [9:0] word;
  logic [9:0] line;
  logic [1:0] pair;
  logic [19:0] hist_next;
  logic [3:0] slip;
  logic [4:0] slip_hi;

  tpe_encoder u_encoder (
    .data_in    (enc_byte),
    .k_in       (enc_k),
    .rd_neg_in  (enc_rd),
    .code_out   (enc_code),
    .rd_neg_out (enc_rd_end)
  );

  always_comb begin
    next_state = state;
    wide       = ctrl_in.enc_en | ctrl_in.width10;
    load       = state.phase >= last_phase(wide);
    // in sync and reset the user byte is replaced by the comma
    if (dreset_in || state.mode == tpe_pkg::TPE_SYNC) begin
      enc_byte = `TPE_COMMA_BYTE;
      enc_k    = 1'h1;
      enc_rd   = state.rd_neg;
    end else begin
      enc_byte = ctrl_in.bitflip ? flip_byte(data_in[7:0]) : data_in[7:0];
      enc_k    = ctrl_in.ctrl_k;
      enc_rd   = ctrl_in.force_disp ? ctrl_in.disp_val : state.rd_neg;
    end
    word = state.code;
    line = state.shreg;
    pair = state.shreg[1:0];
    if (load) begin
      next_state.phase = `TPE_PHASE_ZERO;
      if (!ctrl_in.enc_en) begin
        word = dreset_in ? `TPE_ZERO_WORD : data_in;
        if (ctrl_in.bitflip) begin
          word[7:0] = flip_byte(data_in[7:0]);
        end
        if (!wide) begin
          word[9:8] = 2'h0;
        end
      end else if (dreset_in) begin
        word = `TPE_K285_NEG;
      end else begin
        word              = enc_code;
        next_state.rd_neg = enc_rd_end;
        if (state.mode == tpe_pkg::TPE_SYNC) begin
          next_state.sync_cnt = state.sync_cnt + `TPE_SYNC_STEP;
        end
      end
      line = ctrl_in.invert ? ~word : word;
      if (!wide) begin
        line[9:8] = 2'h0;
      end
      if (ctrl_in.reverse) begin
        line = reverse_word(line, wide);
      end
      next_state.code  = word;
      next_state.shreg = line;
      case (state.mode)
        tpe_pkg::TPE_SYNC: begin
          if (ctrl_in.enc_en && !dreset_in && state.sync_cnt == `TPE_SYNC_LAST) begin
            next_state.mode = tpe_pkg::TPE_DATA;
          end
        end
        tpe_pkg::TPE_DATA: begin
          next_state.mode = tpe_pkg::TPE_DATA;
        end
        default: begin
          next_state.mode = tpe_pkg::TPE_SYNC;
        end
      endcase
    end else begin
      next_state.phase = state.phase + `TPE_PHASE_STEP;
      next_state.shreg = {2'h0, state.shreg[9:2]};
    end
    // reset restarts the comma preamble from the negative column
    if (dreset_in) begin
      next_state.mode     = tpe_pkg::TPE_SYNC;
      next_state.sync_cnt = `TPE_SYNC_ZERO;
      next_state.rd_neg   = 1'h1;
    end
    // raw mode has no preamble to send
    if (!ctrl_in.enc_en && !dreset_in) begin
      next_state.mode = tpe_pkg::TPE_DATA;
    end
    // newest bit in hist_next[0]; a slip of s bits reads s places back
    hist_next = {state.hist[17:0], pair[0], pair[1]};
    slip      = (ctrl_in.slip > `TPE_SLIP_MAX) ? `TPE_SLIP_MAX : ctrl_in.slip;
    slip_hi   = {1'h0, slip} + `TPE_SLIP_STEP;
    next_state.hist = hist_next;
    next_state.ser  = {hist_next[slip], hist_next[slip_hi]};
    next_state.busy = next_state.mode != tpe_pkg::TPE_DATA;
    next_state.take = next_state.phase >= last_phase(wide);
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= RST_STATE;
    end else begin
      state <= next_state;
    end
  end

  assign take_out      = state.take;
  assign ser_out       = state.ser;
  assign code_out      = state.code;
  assign rd_neg_out    = state.rd_neg;
  assign sync_busy_out = state.busy;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  logic comma_in;
  assign comma_in = ctrl_in.ctrl_k && data_in[7:0] == `TPE_COMMA_BYTE && !ctrl_in.bitflip;

  sequence sync_take_s;
    load && ctrl_in.enc_en && !dreset_in && state.mode == tpe_pkg::TPE_SYNC;
  endsequence

  sequence data_comma_s;
    load && ctrl_in.enc_en && !dreset_in && state.mode == tpe_pkg::TPE_DATA && comma_in;
  endsequence

  reset_comma_a: assert property (load && ctrl_in.enc_en && dreset_in |=>
    code_out == `TPE_K285_NEG && rd_neg_out)
    else $error("comma not sent during digital reset");

  sync_start_a: assert property (sync_take_s and state.sync_cnt == `TPE_SYNC_ZERO
    |-> state.rd_neg ##1 code_out == `TPE_K285_NEG)
    else $error("preamble did not start negative");

  // the first preamble comma repeats the reset comma, so compare with disparity, not the old word
  sync_three_a: assert property (sync_take_s |=>
    code_out == ($past(state.rd_neg) ? `TPE_K285_NEG : `TPE_K285_POS))
    else $error("preamble group not an alternating comma");

  sync_exit_a: assert property (sync_take_s and state.sync_cnt == `TPE_SYNC_LAST
    |=> !sync_busy_out)
    else $error("data mode not entered after third comma");

  comma_alt_a: assert property (data_comma_s and !ctrl_in.force_disp |=>
    code_out == ($past(state.rd_neg) ? `TPE_K285_NEG : `TPE_K285_POS) && rd_neg_out != $past(state.rd_neg))
    else $error("comma polarity does not follow running disparity");

  force_pos_a: assert property (data_comma_s and ctrl_in.force_disp && !ctrl_in.disp_val
    |=> code_out == `TPE_K285_POS && rd_neg_out)
    else $error("forced positive comma wrong or disparity not carried");

  force_neg_a: assert property (data_comma_s and ctrl_in.force_disp && ctrl_in.disp_val
    |=> code_out == `TPE_K285_NEG && !rd_neg_out)
    else $error("forced negative comma wrong or disparity not carried");

  invert_word_a: assert property (load && ctrl_in.enc_en && ctrl_in.invert && !ctrl_in.reverse
    |=> state.shreg == ~code_out)
    else $error("serializer word not inverted");

  reverse_word_a: assert property (load && ctrl_in.enc_en && !ctrl_in.invert && ctrl_in.reverse
    |=> state.shreg[0] == code_out[9] && state.shreg[9] == code_out[0])
    else $error("serializer word not reversed");

  lsb_first_a: assert property (ctrl_in.slip == 4'h0 |=>
    ser_out == $past(state.shreg[1:0]))
    else $error("serial pair not least significant first");

  slip_two_a: assert property (ctrl_in.slip == 4'h2 |=>
    ser_out == $past(state.shreg[1:0], 2))
    else $error("two-bit slip not applied");

  sequence flip_comma_s;
    load && ctrl_in.enc_en && !dreset_in && state.mode == tpe_pkg::TPE_DATA && ctrl_in.bitflip;
  endsequence

  flip_comma_a: assert property (flip_comma_s and ctrl_in.ctrl_k && !ctrl_in.force_disp &&
    data_in[7:0] == `TPE_FLIP_COMMA |=> code_out == ($past(state.rd_neg) ? `TPE_K285_NEG : `TPE_K285_POS))
    else $error("flipped byte not encoded as comma");

  raw_word_a: assert property (load && !ctrl_in.enc_en && ctrl_in.width10 && !ctrl_in.bitflip &&
    !dreset_in |=> code_out == $past(data_in))
    else $error("raw word not passed through");

  reset_busy_a: assert property (dreset_in |=> sync_busy_out)
    else $error("busy not held during digital reset");

  take_pulse_a: assert property (take_out |=> !take_out)
    else $error("take strobe longer than one cycle");

endmodule : tpe_tx_pcs

`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  typedef struct packed {
    logic [7:0] data;
    logic       k;
    logic       frc;
    logic       dval;
    logic       flip;
    logic [9:0] code;
    logic       rd_neg;
  } tpe_row_s;
  typedef struct packed {
    logic       w10;
    logic       inv;
    logic       rev;
    logic [3:0] slip;
    logic [9:0] word;
  } tpe_ser_s;

  logic               clk_in;
  logic               nrst_in;
  logic               dreset_in;
  tpe_pkg::tpe_ctrl_s ctrl_in;
  logic         [9:0] data_in;
  tpe_pkg::tpe_ctrl_s next_ctrl;
  logic         [9:0] next_data;
  logic               take_out;
  logic         [1:0] ser_out;
  logic         [9:0] code_out;
  logic               rd_neg_out;
  logic               sync_busy_out;
  logic        [19:0] cap;
  logic         [9:0] pre [3];
  tpe_row_s           rows [12];
  tpe_ser_s           sers [7];
  int                 miscompares = 0;
  int                 checked = 0;
  int                 cycles = 0;
  int                 sl;

  tpe_tx_pcs tpe_tx_pcs_inst (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .dreset_in     (dreset_in),
    .ctrl_in       (ctrl_in),
    .data_in       (data_in),
    .take_out      (take_out),
    .ser_out       (ser_out),
    .code_out      (code_out),
    .rd_neg_out    (rd_neg_out),
    .sync_busy_out (sync_busy_out)
  );

  tpe_fabric_model tpe_fabric_model_inst (
    .clk_in       (clk_in),
    .nrst_in      (nrst_in),
    .take_in      (take_out),
    .next_ctrl_in (next_ctrl),
    .next_data_in (next_data),
    .ctrl_out     (ctrl_in),
    .data_out     (data_in)
  );

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic complete_run();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  // hang guard, the whole run needs well under 600 cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wait_take();
    do @(negedge clk_in); while (take_out !== 1'b1);
  endtask : wait_take

  function automatic tpe_pkg::tpe_ctrl_s mk(input logic enc, w10, flip, inv, rev, frc, dval, k,
                                            input logic [3:0] slip);
    return {enc, w10, flip, inv, rev, frc, dval, k, slip};
  endfunction : mk

  task automatic put(input tpe_row_s r);
    next_data = {2'h0, r.data};
    next_ctrl = mk(1'b1, 1'b1, r.flip, 1'b0, 1'b0, r.frc, r.dval, r.k, 4'h0);
  endtask : put

  function automatic logic [9:0] xf(input tpe_ser_s s);
    logic [9:0] v;
    logic [9:0] r;
    v = s.inv ? ~s.word : s.word;
    if (!s.w10) v[9:8] = 2'h0;
    r = v;
    if (s.rev && s.w10) for (int k = 0; k < 10; k++) r[k] = v[9-k];
    if (s.rev && !s.w10) for (int k = 0; k < 8; k++) r[k] = v[7-k];
    return r;
  endfunction : xf

  initial begin
    nrst_in = 1'b0;
    dreset_in = 1'b1;
    pre = '{10'h17C, 10'h283, 10'h17C};
    // control select only on the comma byte
    rows = '{'{8'hBC, 1'b1, 1'b0, 1'b0, 1'b0, 10'h283, 1'b1}, '{8'hBC, 1'b1, 1'b0, 1'b0, 1'b0, 10'h17C, 1'b0},
             '{8'hBC, 1'b0, 1'b0, 1'b0, 1'b0, 10'h15C, 1'b0}, '{8'hB5, 1'b0, 1'b0, 1'b0, 1'b0, 10'h155, 1'b0},
             '{8'h4A, 1'b0, 1'b0, 1'b0, 1'b0, 10'h2AA, 1'b0}, '{8'hBC, 1'b1, 1'b1, 1'b1, 1'b0, 10'h17C, 1'b0},
             '{8'hBC, 1'b1, 1'b1, 1'b1, 1'b0, 10'h17C, 1'b0}, '{8'hBC, 1'b1, 1'b0, 1'b0, 1'b0, 10'h283, 1'b1},
             '{8'hBC, 1'b1, 1'b1, 1'b0, 1'b0, 10'h283, 1'b1}, '{8'hBC, 1'b1, 1'b0, 1'b0, 1'b0, 10'h17C, 1'b0},
             '{8'h3D, 1'b1, 1'b0, 1'b0, 1'b1, 10'h283, 1'b1}, '{8'hAD, 1'b0, 1'b0, 1'b0, 1'b1, 10'h155, 1'b1}};
    sers = '{'{1'b1, 1'b0, 1'b0, 4'h0, 10'h0F1}, '{1'b1, 1'b1, 1'b0, 4'h0, 10'h0F1},
             '{1'b1, 1'b0, 1'b1, 4'h0, 10'h0F1}, '{1'b1, 1'b0, 1'b0, 4'h2, 10'h0F1},
             '{1'b1, 1'b0, 1'b0, 4'hF, 10'h0F1}, '{1'b0, 1'b0, 1'b0, 4'h0, 10'h0A6},
             '{1'b0, 1'b1, 1'b1, 4'h1, 10'h0A6}};
    // a data byte with forcing on, both to be ignored in reset
    next_data = 10'h0B5;
    next_ctrl = mk(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0);
    repeat (10) @(negedge clk_in);
    check("code_out", code_out, 10'h000);
    check("ser_out", {8'h00, ser_out}, 10'h000);
    check("flags", {7'h00, take_out, rd_neg_out, sync_busy_out}, 10'h003);
    nrst_in = 1'b1;
    repeat (3) begin
      wait_take();
      @(negedge clk_in);
      check("code_out", code_out, 10'h17C);
      check("sync_busy_out", {9'h000, sync_busy_out}, 10'h001);
    end
    dreset_in = 1'b0;
    put(rows[0]);
    for (int i = 0; i < 3; i++) begin
      wait_take();
      @(negedge clk_in);
      check("code_out", code_out, pre[i]);
    end
    @(negedge clk_in);
    check("sync_busy_out", {9'h000, sync_busy_out}, 10'h000);
    for (int i = 0; i < 12; i++) begin
      wait_take();
      if (i < 11) put(rows[i+1]);
      @(negedge clk_in);
      check("code_out", code_out, rows[i].code);
      check("rd_neg_out", {9'h000, rd_neg_out}, {9'h000, rows[i].rd_neg});
    end
    // raw words make the serial pattern independent of the encoder
    for (int i = 0; i < 7; i++) begin
      next_data = sers[i].word;
      next_ctrl = mk(1'b0, sers[i].w10, 1'b0, sers[i].inv, sers[i].rev, 1'b0, 1'b0, 1'b0, sers[i].slip);
      repeat (3) wait_take();
      @(negedge clk_in);
      for (int j = 0; j < 10; j++) begin
        @(negedge clk_in);
        cap[2*j] = ser_out[0];
        cap[2*j+1] = ser_out[1];
      end
      sl = (sers[i].slip > 4'h9) ? 9 : int'(sers[i].slip);
      check("ser_out", sers[i].w10 ? cap[sl +: 10] : {2'h0, cap[sl +: 8]}, xf(sers[i]));
    end
    complete_run();
  end
endmodule : testbench

`default_nettype wire

// ===== tb/tpe_fabric_model.sv
`timescale 1ns/1ps
`default_nettype none

module tpe_fabric_model (
  input  wire logic                clk_in,
  input  wire logic                nrst_in,
  input  wire logic                take_in,
  input  wire tpe_pkg::tpe_ctrl_s  next_ctrl_in,
  input  wire logic          [9:0] next_data_in,
  output var  tpe_pkg::tpe_ctrl_s  ctrl_out,
  output var  logic          [9:0] data_out
);
  initial begin
    ctrl_out = '0;
    data_out = 10'h000;
  end

  // a word stays on the bus until the take edge consumes it; ctrl_k only for control bytes
  always @(posedge clk_in) begin
    if (take_in || !nrst_in) begin
      ctrl_out <= next_ctrl_in;
      data_out <= next_data_in;
    end
  end
endmodule : tpe_fabric_model

`default_nettype wire
